// ---- common/atpg_map.vh ----
`ifndef ATPG_MAP_VH
`define ATPG_MAP_VH
// ==========================================
// Register indices (byte address = index * 4)
`define ATPG_IDX_MODE_A 12'h550
`define ATPG_IDX_USER_FIRST 12'h551
`define ATPG_IDX_USER_LAST 12'h558
`define ATPG_IDX_DDC0 12'h327
`define ATPG_IDX_DDC1 12'h347
`define ATPG_IDX_DDC2 12'h367
`define ATPG_IDX_DDC_LAST 12'h387
`define ATPG_IDX_MODE_B 12'h560
`define ATPG_IDX_CTRL 12'h561
`define ATPG_IDX_STATUS 12'h562
// ==========================================
// Field positions
`define ATPG_MODE_MSB 3
`define ATPG_PN_LONG_RST_BIT 4
`define ATPG_PN_SHORT_RST_BIT 5
`define ATPG_USER_SINGLE_BIT 7
`define ATPG_DDC_I_EN_BIT 0
`define ATPG_DDC_Q_EN_BIT 2
`define ATPG_CTRL_DDC_APP_BIT 0
// ==========================================
// Reset values
`define ATPG_MODE_RST 8'h00
`define ATPG_BYTE_RST 8'h00
// ==========================================
// Mode codes
`define ATPG_M_OFF 4'h0
`define ATPG_M_MID 4'h1
`define ATPG_M_POS 4'h2
`define ATPG_M_NEG 4'h3
`define ATPG_M_CHK 4'h4
`define ATPG_M_PNL 4'h5
`define ATPG_M_PNS 4'h6
`define ATPG_M_TGL 4'h7
`define ATPG_M_USER 4'h8
`define ATPG_M_RAMP 4'hf
// ==========================================
// Pattern words and seeds
`define ATPG_W_ZERO 14'h0000
`define ATPG_W_POS 14'h1fff
`define ATPG_W_NEG 14'h2000
`define ATPG_W_CHK0 14'h1555
`define ATPG_W_CHK1 14'h2aaa
`define ATPG_W_ONES 14'h3fff
`define ATPG_PNL_SEED 23'h003aff
`define ATPG_PNS_SEED 9'h092
`endif

// ---- verilog/atpg_top.v ----
// Notes on behaviour
// - 4-bit mode field; code 0000 off, each other supported code picks one pattern.
// - Any test mode replaces converter samples with the pattern into the output path.
// - Either PN reset bit in the mode register resets the PN generators.
// - Analog input ignored in test mode; patterns advance only on encode ticks.
// - In downconverter mode, patterns go only to downconverters whose enable bits are set.
// - Downconverter in-phase carries channel A pattern, quadrature carries channel B pattern.
// - Fourth downconverter: in-phase takes channel A pattern by one bit; quadrature never.
// - Codes 1,2,3 give zero, 0x1fff and 0x2000 constant words.
// - Code 4 alternates 0x1555 and 0x2aaa sample by sample.
// - Code 5 is the long PN sequence x^23+x^18+1 seeded 0x3aff.
// - Code 6 is the short PN sequence x^9+x^5+1 seeded 0x092.
// - Code 7 alternates 0x0000 and 0x3fff, starting with zero.
// - Code 8 plays user words bits [15:2] in order, repeating after the fourth.
// - Single user mode (bit 7 of mode_a_reg only, for both channels) plays the four words once, then zeros continuously.
// - Code 15 is a ramp incrementing by one per sample, wrapping at 2^14.
//
// The address map and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "atpg_map.vh"
module atpg_top #(
	parameter DW = 14,
	parameter NDDC = 4
) (
	// Clock and reset
	input wire hclk,
	input wire hresetn,
	// AHB-Lite slave
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg hreadyout,
	output reg [31:0] hrdata,
	output reg hresp,
	// Converter and downconverter samples in
	input wire enc_tick,
	input wire [DW-1:0] adc_a_data,
	input wire [DW-1:0] adc_b_data,
	input wire [NDDC*DW-1:0] ddc_i_in,
	input wire [NDDC*DW-1:0] ddc_q_in,
	// Formatted sample stream out
	output reg out_valid,
	input wire out_ready,
	output reg [DW-1:0] out_a_data,
	output reg [DW-1:0] out_b_data,
	output reg [NDDC*DW-1:0] ddc_i_out,
	output reg [NDDC*DW-1:0] ddc_q_out
);
	localparam BW = 2*DW + 2*NDDC*DW;
	// ==========================================
	// Functions
	function [13:0] atpg_pattern;
		input [3:0] mode;
		input phase;
		input [13:0] pnl;
		input [13:0] pns;
		input [13:0] ramp;
		input [13:0] user;
		input udone;
		begin
			case (mode)
				`ATPG_M_MID: atpg_pattern = `ATPG_W_ZERO;
				`ATPG_M_POS: atpg_pattern = `ATPG_W_POS;
				`ATPG_M_NEG: atpg_pattern = `ATPG_W_NEG;
				`ATPG_M_CHK: atpg_pattern = phase ? `ATPG_W_CHK1 : `ATPG_W_CHK0;
				`ATPG_M_PNL: atpg_pattern = pnl;
				`ATPG_M_PNS: atpg_pattern = pns;
				`ATPG_M_TGL: atpg_pattern = phase ? `ATPG_W_ONES : `ATPG_W_ZERO;
				`ATPG_M_USER: atpg_pattern = udone ? `ATPG_W_ZERO : user;
				`ATPG_M_RAMP: atpg_pattern = ramp;
				default: atpg_pattern = `ATPG_W_ZERO;
			endcase
		end
	endfunction
	// Long PN: 14 shifts, returns {next state, sample}
	function [36:0] atpg_pnl_step;
		input [22:0] s;
		reg [22:0] st;
		reg [13:0] o;
		integer i;
		begin
			st = s;
			o = 14'h0000;
			for (i = 0; i < 14; i = i + 1)
			begin
				o = {o[12:0], st[0]};
				st = {st[0] ^ st[5], st[22:1]};
			end
			atpg_pnl_step = {st, o};
		end
	endfunction
	// Short PN: 14 shifts, returns {next state, sample}
	function [22:0] atpg_pns_step;
		input [8:0] s;
		reg [8:0] st;
		reg [13:0] o;
		integer i;
		begin
			st = s;
			o = 14'h0000;
			for (i = 0; i < 14; i = i + 1)
			begin
				o = {o[12:0], st[0]};
				st = {st[0] ^ st[4], st[8:1]};
			end
			atpg_pns_step = {st, o};
		end
	endfunction
	// ==========================================
	// Registers
	reg [7:0] mode_a_reg;
	reg [7:0] mode_b_reg;
	reg [7:0] user_reg [0:7];
	reg [NDDC-1:0] ddc_i_en_reg;
	reg [NDDC-2:0] ddc_q_en_reg;
	reg ddc_app_reg;
	reg dp_pend_reg;
	reg dp_write_reg;
	reg [11:0] dp_idx_reg;
	reg phase_reg;
	reg [13:0] ramp_reg;
	reg [1:0] uidx_reg;
	reg udone_reg;
	reg [22:0] pnl_reg;
	reg [8:0] pns_reg;
	reg skid_valid_reg;
	reg [BW-1:0] skid_data_reg;
	integer k;
	// ==========================================
	// AHB-Lite slave, one wait state per transfer
	wire addr_ok = hsel && hready && htrans[1];
	wire wr_now = dp_pend_reg && dp_write_reg;
	reg [31:0] rd_mux;
	always @*
	begin
		rd_mux = 32'h00000000;
		case (dp_idx_reg)
			`ATPG_IDX_MODE_A: rd_mux = {24'h000000, mode_a_reg};
			`ATPG_IDX_MODE_B: rd_mux = {24'h000000, mode_b_reg};
			`ATPG_IDX_DDC0: rd_mux = {29'h0, ddc_q_en_reg[0], 1'b0, ddc_i_en_reg[0]};
			`ATPG_IDX_DDC1: rd_mux = {29'h0, ddc_q_en_reg[1], 1'b0, ddc_i_en_reg[1]};
			`ATPG_IDX_DDC2: rd_mux = {29'h0, ddc_q_en_reg[2], 1'b0, ddc_i_en_reg[2]};
			`ATPG_IDX_DDC_LAST: rd_mux = {31'h0, ddc_i_en_reg[3]};
			`ATPG_IDX_CTRL: rd_mux = {31'h0, ddc_app_reg};
			`ATPG_IDX_STATUS: rd_mux = {27'h0, skid_valid_reg, udone_reg, uidx_reg, phase_reg};
			default:
			begin
				if (dp_idx_reg >= `ATPG_IDX_USER_FIRST && dp_idx_reg <= `ATPG_IDX_USER_LAST)
					rd_mux = {24'h000000, user_reg[dp_idx_reg[2:0] - 3'h1]};
			end
		endcase
	end
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h00000000;
			dp_pend_reg <= 1'b0;
			dp_write_reg <= 1'b0;
			dp_idx_reg <= 12'h000;
		end
		else if (dp_pend_reg)
		begin
			dp_pend_reg <= 1'b0;
			hreadyout <= 1'b1;
			if (!dp_write_reg)
				hrdata <= rd_mux;
		end
		else if (addr_ok)
		begin
			dp_pend_reg <= 1'b1;
			hreadyout <= 1'b0;
			dp_write_reg <= hwrite;
			dp_idx_reg <= haddr[13:2];
		end
	end
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			mode_a_reg <= `ATPG_MODE_RST;
			mode_b_reg <= `ATPG_MODE_RST;
			ddc_i_en_reg <= {NDDC{1'b0}};
			ddc_q_en_reg <= {(NDDC-1){1'b0}};
			ddc_app_reg <= 1'b0;
			for (k = 0; k < 8; k = k + 1)
				user_reg[k] <= `ATPG_BYTE_RST;
		end
		else if (wr_now)
		begin
			case (dp_idx_reg)
				`ATPG_IDX_MODE_A: mode_a_reg <= hwdata[7:0];
				`ATPG_IDX_MODE_B: mode_b_reg <= hwdata[7:0];
				`ATPG_IDX_DDC0:
				begin
					ddc_i_en_reg[0] <= hwdata[`ATPG_DDC_I_EN_BIT];
					ddc_q_en_reg[0] <= hwdata[`ATPG_DDC_Q_EN_BIT];
				end
				`ATPG_IDX_DDC1:
				begin
					ddc_i_en_reg[1] <= hwdata[`ATPG_DDC_I_EN_BIT];
					ddc_q_en_reg[1] <= hwdata[`ATPG_DDC_Q_EN_BIT];
				end
				`ATPG_IDX_DDC2:
				begin
					ddc_i_en_reg[2] <= hwdata[`ATPG_DDC_I_EN_BIT];
					ddc_q_en_reg[2] <= hwdata[`ATPG_DDC_Q_EN_BIT];
				end
				`ATPG_IDX_DDC_LAST: ddc_i_en_reg[3] <= hwdata[`ATPG_DDC_I_EN_BIT];
				`ATPG_IDX_CTRL: ddc_app_reg <= hwdata[`ATPG_CTRL_DDC_APP_BIT];
				default:
				begin
					if (dp_idx_reg >= `ATPG_IDX_USER_FIRST && dp_idx_reg <= `ATPG_IDX_USER_LAST)
						user_reg[dp_idx_reg[2:0] - 3'h1] <= hwdata[7:0];
				end
			endcase
		end
	end
	// ==========================================
	// Pattern sequencer
	wire [3:0] mode_a = mode_a_reg[`ATPG_MODE_MSB:0];
	wire [3:0] mode_b = mode_b_reg[`ATPG_MODE_MSB:0];
	wire test_a = (mode_a != `ATPG_M_OFF);
	wire test_b = (mode_b != `ATPG_M_OFF);
	wire pn_rst = mode_a_reg[`ATPG_PN_LONG_RST_BIT] || mode_a_reg[`ATPG_PN_SHORT_RST_BIT]
		|| mode_b_reg[`ATPG_PN_LONG_RST_BIT] || mode_b_reg[`ATPG_PN_SHORT_RST_BIT];
	wire in_ready = !skid_valid_reg;
	wire push = enc_tick && in_ready;
	wire restart = wr_now && (dp_idx_reg == `ATPG_IDX_MODE_A || dp_idx_reg == `ATPG_IDX_MODE_B);
	wire [36:0] pnl_nx = atpg_pnl_step(pnl_reg);
	wire [22:0] pns_nx = atpg_pns_step(pns_reg);
	wire [13:0] user_word = uidx_reg == 2'h0 ? {user_reg[1], user_reg[0][7:2]} :
		uidx_reg == 2'h1 ? {user_reg[3], user_reg[2][7:2]} :
		uidx_reg == 2'h2 ? {user_reg[5], user_reg[4][7:2]} : {user_reg[7], user_reg[6][7:2]};
	wire [13:0] pat_a = atpg_pattern(mode_a, phase_reg, pnl_nx[13:0], pns_nx[13:0], ramp_reg, user_word, udone_reg);
	wire [13:0] pat_b = atpg_pattern(mode_b, phase_reg, pnl_nx[13:0], pns_nx[13:0], ramp_reg, user_word, udone_reg);
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			phase_reg <= 1'b0;
			ramp_reg <= 14'h0000;
			uidx_reg <= 2'h0;
			udone_reg <= 1'b0;
			pnl_reg <= `ATPG_PNL_SEED;
			pns_reg <= `ATPG_PNS_SEED;
		end
		else
		begin
			if (restart)
			begin
				phase_reg <= 1'b0;
				uidx_reg <= 2'h0;
				udone_reg <= 1'b0;
			end
			else if (push)
			begin
				phase_reg <= !phase_reg;
				uidx_reg <= uidx_reg + 2'h1;
				if (uidx_reg == 2'h3 && mode_a_reg[`ATPG_USER_SINGLE_BIT])
					udone_reg <= 1'b1;
			end
			if (push)
				ramp_reg <= ramp_reg + 14'h0001;
			if (pn_rst)
			begin
				pnl_reg <= `ATPG_PNL_SEED;
				pns_reg <= `ATPG_PNS_SEED;
			end
			else if (push)
			begin
				pnl_reg <= pnl_nx[36:14];
				pns_reg <= pns_nx[22:14];
			end
		end
	end
	// ==========================================
	// Sample assembly
	wire [DW-1:0] smp_a = test_a ? pat_a : adc_a_data;
	wire [DW-1:0] smp_b = test_b ? pat_b : adc_b_data;
	wire [NDDC*DW-1:0] smp_i;
	wire [NDDC*DW-1:0] smp_q;
	genvar g;
	generate
		for (g = 0; g < NDDC; g = g + 1)
		begin : g_ddc
			assign smp_i[g*DW +: DW] = (ddc_app_reg && test_a && ddc_i_en_reg[g]) ? pat_a
				: ddc_i_in[g*DW +: DW];
			if (g == NDDC - 1)
			begin : g_last
				assign smp_q[g*DW +: DW] = ddc_q_in[g*DW +: DW];
			end
			else
			begin : g_rest
				assign smp_q[g*DW +: DW] = (ddc_app_reg && test_b && ddc_q_en_reg[g]) ? pat_b
					: ddc_q_in[g*DW +: DW];
			end
		end
	endgenerate
	wire [BW-1:0] in_data = {smp_a, smp_b, smp_i, smp_q};
	// ==========================================
	// Two-entry output buffer
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			out_valid <= 1'b0;
			out_a_data <= {DW{1'b0}};
			out_b_data <= {DW{1'b0}};
			ddc_i_out <= {(NDDC*DW){1'b0}};
			ddc_q_out <= {(NDDC*DW){1'b0}};
			skid_valid_reg <= 1'b0;
			skid_data_reg <= {BW{1'b0}};
		end
		else if (push)
		begin
			if (!out_valid || out_ready)
			begin
				out_valid <= 1'b1;
				{out_a_data, out_b_data, ddc_i_out, ddc_q_out} <= in_data;
			end
			else
			begin
				skid_valid_reg <= 1'b1;
				skid_data_reg <= in_data;
			end
		end
		else if (out_valid && out_ready)
		begin
			if (skid_valid_reg)
			begin
				{out_a_data, out_b_data, ddc_i_out, ddc_q_out} <= skid_data_reg;
				skid_valid_reg <= 1'b0;
			end
			else
				out_valid <= 1'b0;
		end
	end
endmodule // atpg_top
`default_nettype wire

// ---- verif/atpg_top_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module atpg_chk #(
	parameter DW = 14,
	parameter NDDC = 4
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Bus
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic hresp,
	// Stream
	input wire logic enc_tick,
	input wire logic out_valid,
	input wire logic out_ready,
	input wire logic [DW-1:0] out_a_data,
	input wire logic [DW-1:0] out_b_data,
	input wire logic [NDDC*DW-1:0] ddc_i_out,
	input wire logic [NDDC*DW-1:0] ddc_q_out
);
	// ====
	// Checks
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	wire start = hsel && hready && htrans[1];
	bus_okay_a: assert property (hresp == 1'b0)
		else $error("hresp not OKAY");
	bus_wait_a: assert property (start |=> !hreadyout ##1 hreadyout)
		else $error("wait state wrong");
	read_upper_a: assert property (start && !hwrite |=> ##1 hrdata[31:8] == 24'h0)
		else $error("read upper bits set");
	rdata_hold_a: assert property (!$rose(hreadyout) |-> $stable(hrdata))
		else $error("hrdata changed mid transfer");
	stream_hold_a: assert property (out_valid && !out_ready |=> out_valid &&
		$stable({out_a_data, out_b_data, ddc_i_out, ddc_q_out}))
		else $error("stalled word changed");
	tick_word_a: assert property (enc_tick && !out_valid |=> out_valid)
		else $error("tick gave no word");
	idle_quiet_a: assert property (!out_valid && !enc_tick |=> !out_valid)
		else $error("word without tick");
	drain_only_a: assert property ($fell(out_valid) |-> $past(out_ready))
		else $error("word dropped");
	cover property (start && !hwrite);
	cover property (out_valid && !out_ready ##1 enc_tick);
	cover property (enc_tick ##1 out_valid && out_ready);
endmodule // atpg_chk
bind atpg_top atpg_chk #(.DW(DW), .NDDC(NDDC)) u_chk (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
	.hreadyout, .hrdata, .hresp, .enc_tick, .out_valid, .out_ready, .out_a_data, .out_b_data, .ddc_i_out,
	.ddc_q_out);
`default_nettype wire

// ---- verif/atpg_sink.sv ----
`timescale 1ns/1ps
`default_nettype none
module atpg_sink (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Stream
	input wire logic out_valid,
	input wire logic stall,
	input wire logic [13:0] a,
	input wire logic [13:0] b,
	output logic out_ready
);
	// ====
	// Word store, stalls on request
	logic [27:0] q[$];
	assign out_ready = !stall;
	always @(posedge hclk)
		if (hresetn && out_valid && out_ready)
			q.push_back({a, b});
endmodule // atpg_sink
`default_nettype wire

// ---- verif/test_adc_test_pattern_generator.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "atpg_map.vh"
module test_adc_test_pattern_generator;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, enc_tick = 0, stall = 0;
	logic hreadyout, hresp, out_valid, out_ready;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
	logic [1:0] htrans = 0;
	logic [13:0] adc_a = 14'h0abc, adc_b = 14'h0123, oa, ob;
	logic [55:0] ddc_i = {4{14'h0abc}}, ddc_q = {4{14'h0123}}, ddc_i_out, ddc_q_out;
	int failures = 0, checks_done = 0;
	logic [15:0] up[4] = '{16'h1234, 16'habcd, 16'hfffc, 16'h0004};
	logic [7:0] md[6] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h07, 8'h09};
	logic [13:0] e0[6] = '{14'h0, 14'h1fff, 14'h2000, 14'h1555, 14'h0, 14'h0};
	logic [13:0] e1[6] = '{14'h0, 14'h1fff, 14'h2000, 14'h2aaa, 14'h3fff, 14'h0};
	logic [13:0] pn[10] = '{14'h3fd7, 14'h0002, 14'h26e0, 14'h0a3d, 14'h1ca6,
		14'h125b, 14'h3c9a, 14'h2660, 14'h0c65, 14'h0697};
	always #50 hclk = ~hclk;
	atpg_top u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
		.hreadyout, .hrdata, .hresp, .enc_tick, .adc_a_data(adc_a), .adc_b_data(adc_b), .ddc_i_in(ddc_i),
		.ddc_q_in(ddc_q), .out_valid, .out_ready, .out_a_data(oa), .out_b_data(ob), .ddc_i_out, .ddc_q_out);
	atpg_sink u_sink (.hclk, .hresetn, .out_valid, .stall, .a(oa), .b(ob), .out_ready);
	// ====
	// Tasks
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		checks_done++;
		if (s !== e)
		begin
			failures++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	task xfer(input logic w, input logic [11:0] i, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {18'h0, i, 2'h0};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		r = hrdata;
	endtask
	task rd(input string n, input logic [11:0] i, input logic [31:0] e);
		xfer(0, i, 32'h0);
		chk(n, e, r);
	endtask
	task run(input int n);
		u_sink.q.delete();
		repeat (n)
		begin
			@(posedge hclk);
			enc_tick <= 1;
		end
		@(posedge hclk);
		enc_tick <= 0;
		repeat (4) @(posedge hclk);
	endtask
	function logic [13:0] qa(input int j);
		return u_sink.q[j][27:14];
	endfunction
	task test_done;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ====
	// Tests
	initial
	begin
		repeat (5000) @(posedge hclk);
		failures++;
		test_done;
	end
	initial
	begin
		repeat (2) @(posedge hclk);
		hresetn <= 1;
		rd("mode reset", `ATPG_IDX_MODE_A, 32'h0);
		xfer(1, 12'h123, 32'h5a);
		rd("unmapped", 12'h123, 32'h0);
		run(1);
		chk("passthrough", {adc_a, adc_b}, u_sink.q[0]);
		$display("test passthrough done");
		for (int k = 0; k < 6; k++)
		begin
			xfer(1, `ATPG_IDX_MODE_A, md[k]);
			run(3);
			chk("const0", e0[k], qa(0));
			chk("const1", e1[k], qa(1));
			chk("const2", e0[k], qa(2));
		end
		$display("test constants done");
		for (int k = 0; k < 2; k++)
		begin
			xfer(1, `ATPG_IDX_MODE_A, k ? 32'h26 : 32'h15);
			xfer(1, `ATPG_IDX_MODE_A, k ? 32'h06 : 32'h05);
			run(5);
			for (int j = 0; j < 5; j++)
				chk("pn", pn[k*5+j], qa(j));
		end
		$display("test pn done");
		for (int k = 0; k < 4; k++)
		begin
			xfer(1, `ATPG_IDX_USER_FIRST + 2*k, up[k][7:0]);
			xfer(1, `ATPG_IDX_USER_FIRST + 2*k + 1, up[k][15:8]);
		end
		rd("user byte", `ATPG_IDX_USER_FIRST + 3, 32'hab);
		xfer(1, `ATPG_IDX_MODE_A, 32'h08);
		run(6);
		for (int j = 0; j < 6; j++)
			chk("user repeat", up[j%4][15:2], qa(j));
		xfer(1, `ATPG_IDX_MODE_A, 32'h88);
		rd("mode back", `ATPG_IDX_MODE_A, 32'h88);
		run(6);
		for (int j = 0; j < 6; j++)
			chk("user single", j < 4 ? up[j][15:2] : 14'h0, qa(j));
		$display("test user done");
		xfer(1, `ATPG_IDX_MODE_A, 32'h0f);
		stall <= 1;
		run(4);
		stall <= 0;
		repeat (4) @(posedge hclk);
		chk("kept", 2, u_sink.q.size());
		chk("ramp", 14'(qa(0) + 14'h1), qa(1));
		$display("test ramp stall done");
		xfer(1, `ATPG_IDX_MODE_B, 32'h02);
		xfer(1, `ATPG_IDX_MODE_A, 32'h03);
		xfer(1, `ATPG_IDX_CTRL, 32'h01);
		xfer(1, `ATPG_IDX_DDC0, 32'h05);
		xfer(1, `ATPG_IDX_DDC_LAST, 32'h01);
		stall <= 1;
		run(1);
		chk("i0", 14'h2000, ddc_i_out[13:0]);
		chk("q0", 14'h1fff, ddc_q_out[13:0]);
		chk("i1", 14'h0abc, ddc_i_out[27:14]);
		chk("i3", 14'h2000, ddc_i_out[55:42]);
		chk("q3", 14'h0123, ddc_q_out[55:42]);
		chk("a neg", 14'h2000, oa);
		chk("b pos", 14'h1fff, ob);
		stall <= 0;
		$display("test ddc done");
		test_done;
	end
endmodule // test_adc_test_pattern_generator
`default_nettype wire
